// *** design/homing_method_sequencer.sv ***
// homing sequencer: positive-limit tail of the preceding method and method 26
//
// Behaviour
// R1 - preceding method limit case: index rise gives positive low, index fall negative low
// R2 - preceding method limit case: stop on home switch rise after index steps
// R3 - case 26.1 starts positive direction, high speed
// R4 - case 26.1: home switch rise drops to low speed, still positive
// R5 - case 26.1: index fall keeps positive low speed
// R6 - case 26.1: subsequent home switch fall stops the axis
// R7 - case 26.2 starts positive direction, low speed
// R8 - case 26.2: after home fall keep forward, stop on next home fall
// R9 - case 26.3: limit before home switch reverses to negative high speed
// R10 - case 26.3: index rise gives positive low, index fall keeps positive low
// R11 - case 26.3: home switch fall after index steps stops the axis
// R12 - home switch edge, not index, is the final origin
// R13 - case at start: home active means valid, else free; a limit hit while seeking changes it to limit
module homing_method_sequencer
    import homing_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic START,
    input wire logic ABORT,
    input wire logic PREV_METHOD,
    input wire logic HOME_SW,
    input wire logic POS_LIMIT,
    input wire logic INDEX,
    output motion_s MOTION,
    output case_e CASE_ID,
    output logic BUSY,
    output logic HOMED,
    output logic ORIGIN_STROBE
);

    typedef enum {
        ST_IDLE,
        ST_SEEK_FAST,
        ST_FREE_SLOW,
        ST_FREE_FINAL,
        ST_VALID_FIRST,
        ST_VALID_FINAL,
        ST_REV_FAST,
        ST_REV_INDEX,
        ST_LIMIT_FINAL
    } state_e;

    ////////////////////////////////////////////////////////////////////////
    // edge detection

    function automatic logic rise(input logic prev, input logic cur);
        rise = !prev && cur;
    endfunction : rise

    function automatic logic fall(input logic prev, input logic cur);
        fall = prev && !cur;
    endfunction : fall

    logic home_d_r;
    logic index_d_r;
    logic home_rise;
    logic home_fall;
    logic index_rise;
    logic index_fall;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            home_d_r <= INPUTS_RESET;
            index_d_r <= INPUTS_RESET;
        end else begin
            home_d_r <= HOME_SW;
            index_d_r <= INDEX;
        end
    end

    assign home_rise = rise(home_d_r, HOME_SW);
    assign home_fall = fall(home_d_r, HOME_SW);
    assign index_rise = rise(index_d_r, INDEX);
    assign index_fall = fall(index_d_r, INDEX);

    ////////////////////////////////////////////////////////////////////////
    // sequence

    state_e state_r;
    state_e state_nxt;
    motion_s motion_nxt;
    case_e case_nxt;
    logic prev_r;
    logic origin_nxt;
    logic start_take;

    assign start_take = (state_r == ST_IDLE) && START;

    always_comb begin
        state_nxt = state_r;
        motion_nxt = MOTION;
        case_nxt = CASE_ID;
        origin_nxt = 1'h0;
        case (state_r)
            ST_IDLE: begin
                if (START) begin
                    if (HOME_SW) begin
                        state_nxt = ST_VALID_FIRST; // R13
                        motion_nxt = MOTION_POS_LOW; // R7
                        case_nxt = CASE_VALID; // R13
                    end else begin
                        state_nxt = ST_SEEK_FAST;
                        motion_nxt = MOTION_POS_HIGH; // R3
                        case_nxt = CASE_INVALID_FREE; // R13
                    end
                end
            end
            ST_SEEK_FAST: begin
                if (POS_LIMIT) begin
                    state_nxt = ST_REV_FAST;
                    motion_nxt = MOTION_NEG_HIGH; // R9
                    case_nxt = CASE_INVALID_LIMIT; // R13
                end else if (home_rise) begin
                    state_nxt = ST_FREE_SLOW;
                    motion_nxt = MOTION_POS_LOW; // R4
                end
            end
            ST_FREE_SLOW: begin
                if (index_fall) begin
                    state_nxt = ST_FREE_FINAL;
                    motion_nxt = MOTION_POS_LOW; // R5
                end
            end
            ST_FREE_FINAL: begin
                if (home_fall) begin
                    state_nxt = ST_IDLE;
                    motion_nxt = MOTION_STOP; // R6
                    origin_nxt = 1'h1; // R12
                end
            end
            ST_VALID_FIRST: begin
                if (home_fall) begin
                    state_nxt = ST_VALID_FINAL;
                    motion_nxt = MOTION_POS_LOW; // R8
                end
            end
            ST_VALID_FINAL: begin
                if (home_fall) begin
                    state_nxt = ST_IDLE;
                    motion_nxt = MOTION_STOP; // R8
                    origin_nxt = 1'h1; // R12
                end
            end
            ST_REV_FAST: begin
                if (index_rise) begin
                    state_nxt = ST_REV_INDEX;
                    motion_nxt = MOTION_POS_LOW; // R1 R10
                end
            end
            ST_REV_INDEX: begin
                if (index_fall) begin
                    state_nxt = ST_LIMIT_FINAL;
                    motion_nxt = prev_r ? MOTION_NEG_LOW : MOTION_POS_LOW; // R1 R10
                end
            end
            ST_LIMIT_FINAL: begin
                if ((prev_r && home_rise) || (!prev_r && home_fall)) begin
                    state_nxt = ST_IDLE;
                    motion_nxt = MOTION_STOP; // R2 R11
                    origin_nxt = 1'h1; // R12
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                motion_nxt = MOTION_STOP;
            end
        endcase
        if (ABORT) begin
            state_nxt = ST_IDLE;
            motion_nxt = MOTION_STOP;
            case_nxt = CASE_ID;
            origin_nxt = 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state and outputs

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            state_r <= ST_IDLE;
            MOTION <= MOTION_STOP;
            CASE_ID <= CASE_NONE;
            BUSY <= 1'h0;
            ORIGIN_STROBE <= 1'h0;
        end else begin
            state_r <= state_nxt;
            MOTION <= motion_nxt;
            CASE_ID <= case_nxt;
            BUSY <= (state_nxt != ST_IDLE);
            ORIGIN_STROBE <= origin_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // method latch

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            prev_r <= 1'h0;
        end else if (start_take) begin
            prev_r <= PREV_METHOD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // homed flag, abort clear wins over a same-cycle origin set

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            HOMED <= 1'h0;
        end else if (origin_nxt) begin
            HOMED <= 1'h1; // R12
        end else if (start_take || ABORT) begin
            HOMED <= 1'h0;
        end
    end

endmodule : homing_method_sequencer

// *** inc/homing_pkg.sv ***
// shared types and constants of the homing sequencer
package homing_pkg;

    typedef struct packed {
        logic run;
        logic neg;
        logic high;
    } motion_s;

    typedef enum logic [1:0] {
        CASE_NONE,
        CASE_INVALID_FREE,
        CASE_VALID,
        CASE_INVALID_LIMIT
    } case_e;

    localparam motion_s MOTION_STOP = '{run: 1'h0, neg: 1'h0, high: 1'h0};
    localparam motion_s MOTION_POS_HIGH = '{run: 1'h1, neg: 1'h0, high: 1'h1};
    localparam motion_s MOTION_POS_LOW = '{run: 1'h1, neg: 1'h0, high: 1'h0};
    localparam motion_s MOTION_NEG_HIGH = '{run: 1'h1, neg: 1'h1, high: 1'h1};
    localparam motion_s MOTION_NEG_LOW = '{run: 1'h1, neg: 1'h1, high: 1'h0};

    localparam logic INPUTS_RESET = 1'h0;

endpackage : homing_pkg

// *** bench/homing_asserts.sv ***
// port assertions of the homing sequencer
module homing_asserts
    import homing_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic START,
    input wire logic ABORT,
    input wire logic PREV_METHOD,
    input wire logic HOME_SW,
    input wire logic POS_LIMIT,
    input wire logic INDEX,
    input motion_s MOTION,
    input case_e CASE_ID,
    input wire logic BUSY,
    input wire logic HOMED,
    input wire logic ORIGIN_STROBE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    wire go = !BUSY && START && !ABORT;
    AST_SEEK: assert property (go && !HOME_SW |=> MOTION == MOTION_POS_HIGH)
        else $error("seek start wrong");
    AST_VALID: assert property (go && HOME_SW |=>
        MOTION == MOTION_POS_LOW && CASE_ID == CASE_VALID)
        else $error("valid start wrong");
    AST_REV: assert property (BUSY && MOTION == MOTION_POS_HIGH && POS_LIMIT && !ABORT
        |=> MOTION == MOTION_NEG_HIGH)
        else $error("no reversal");
    AST_SLOW: assert property (MOTION == MOTION_POS_HIGH && $rose(HOME_SW)
        && !POS_LIMIT && !ABORT |=> MOTION == MOTION_POS_LOW)
        else $error("no slow down");
    AST_IDX: assert property (MOTION == MOTION_NEG_HIGH && $rose(INDEX) && !ABORT
        |=> MOTION == MOTION_POS_LOW)
        else $error("index rise ignored");
    AST_STOP: assert property (ORIGIN_STROBE |-> !MOTION.run && HOMED && !BUSY)
        else $error("strobe without stop");
    AST_CAUSE: assert property (ORIGIN_STROBE |-> $past(HOME_SW) != $past(HOME_SW, 2))
        else $error("origin not on home edge");
    AST_PULSE: assert property (ORIGIN_STROBE |=> !ORIGIN_STROBE)
        else $error("strobe too long");
    AST_ABORT: assert property (ABORT |=> !BUSY && !MOTION.run && !HOMED)
        else $error("abort ignored");
endmodule : homing_asserts

// *** bench/switch_model.sv ***
// home switch, limit switch and index source
module switch_model (
    input wire logic clk,
    input wire logic [2:0] want,
    output logic home_sw,
    output logic pos_limit,
    output logic index_p
);
    timeunit 1ns;
    timeprecision 1ps;
    assign {home_sw, pos_limit, index_p} = want;
endmodule : switch_model

// *** bench/tb.sv ***
// self-checking bench of the homing sequencer
module tb import homing_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'h0, resetn = 1'h0, start = 1'h0, abort = 1'h0, prev = 1'h0;
    logic [2:0] want = 3'h0;
    logic home, lim, idx, busy, homed, strobe;
    motion_s motion;
    case_e case_id;
    int n_errors = 0, check_count = 0;
    always #5 clock = ~clock;
    switch_model sw (.clk(clock), .want(want), .home_sw(home), .pos_limit(lim), .index_p(idx));
    homing_method_sequencer dut (.CLOCK(clock), .RESETN(resetn), .START(start), .ABORT(abort),
        .PREV_METHOD(prev), .HOME_SW(home), .POS_LIMIT(lim), .INDEX(idx), .MOTION(motion),
        .CASE_ID(case_id), .BUSY(busy), .HOMED(homed), .ORIGIN_STROBE(strobe));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic sm(input logic [2:0] w, input motion_s m);
        @(negedge clock) want = w;
        @(negedge clock);
        chk("motion", 8'(motion), 8'(m));
    endtask : sm
    task automatic hs(input logic p, input logic [2:0] w, input case_e c, input motion_s m);
        @(negedge clock) want = w;
        prev = p;
        @(negedge clock) start = 1'h1;
        @(negedge clock) start = 1'h0;
        chk("case", 8'(case_id), 8'(c));
        chk("motion", 8'(motion), 8'(m));
    endtask : hs
    task automatic fin(input string t);
        chk("done", 8'({busy, homed, strobe}), 8'h03);
        @(negedge clock);
        chk("pulse", 8'(strobe), 8'h00);
        $display("test %s done", t);
    endtask : fin
    task automatic t_free();
        hs(1'h0, 3'h0, CASE_INVALID_FREE, MOTION_POS_HIGH);
        sm(3'h4, MOTION_POS_LOW);
        sm(3'h5, MOTION_POS_LOW);
        sm(3'h4, MOTION_POS_LOW);
        sm(3'h0, MOTION_STOP);
        fin("free");
    endtask : t_free
    task automatic t_valid();
        hs(1'h0, 3'h4, CASE_VALID, MOTION_POS_LOW);
        sm(3'h0, MOTION_POS_LOW);
        sm(3'h4, MOTION_POS_LOW);
        sm(3'h0, MOTION_STOP);
        fin("valid");
    endtask : t_valid
    task automatic t_limit(input logic p);
        hs(p, 3'h0, CASE_INVALID_FREE, MOTION_POS_HIGH);
        sm(3'h2, MOTION_NEG_HIGH);
        chk("case", 8'(case_id), 8'(CASE_INVALID_LIMIT));
        sm(3'h0, MOTION_NEG_HIGH);
        sm(3'h1, MOTION_POS_LOW);
        sm(3'h0, p ? MOTION_NEG_LOW : MOTION_POS_LOW);
        sm(3'h4, p ? MOTION_STOP : MOTION_POS_LOW);
        if (!p) sm(3'h0, MOTION_STOP);
        fin(p ? "prev" : "limit");
    endtask : t_limit
    task automatic t_abort();
        hs(1'h0, 3'h0, CASE_INVALID_FREE, MOTION_POS_HIGH);
        @(negedge clock) abort = 1'h1;
        @(negedge clock) abort = 1'h0;
        chk("abort", 8'({busy, homed, motion}), 8'h00);
        $display("test abort done");
    endtask : t_abort
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (8) @(negedge clock);
        resetn = 1'h1;
        t_free();
        t_valid();
        t_limit(1'h0);
        t_limit(1'h1);
        t_abort();
        stop_test();
    end
    initial begin
        repeat (2000) @(posedge clock);
        n_errors++;
        stop_test();
    end
endmodule : tb
bind homing_method_sequencer homing_asserts u_chk (.CLOCK, .RESETN, .START, .ABORT,
    .PREV_METHOD, .HOME_SW, .POS_LIMIT, .INDEX, .MOTION, .CASE_ID, .BUSY, .HOMED,
    .ORIGIN_STROBE);
